// File: core/addr_map.sv
`default_nettype none
module addr_map (
    // host physical address
    input wire logic [31:0] phys_addr,
    // device geometry
    input wire sdram_pkg::geom_s geom,
    // row, column and bank for the memory
    output sdram_pkg::dram_addr_s mapped
);

    int hi;

    // ****************************************
    // linear address to row, column, bank
    // ****************************************
    // low three bits pick a byte and never reach the pins
    always_comb begin
        hi = geom.four_bank ? sdram_pkg::HI_BASE_4B : sdram_pkg::HI_BASE_2B;
        mapped = '0;
        for (int i = 0; i < sdram_pkg::ROW_MIN; i++) begin
            mapped.row[i] = phys_addr[sdram_pkg::ROW_POS + i];
        end
        for (int i = 0; i < sdram_pkg::COL_MIN; i++) begin
            mapped.col[i] = phys_addr[sdram_pkg::COL_POS + i];
        end
        // extra row bits above bank selects, top bit first on two banks
        for (int k = 0; k < 2; k++) begin
            if (k < int'(geom.row_extra)) begin
                mapped.row[geom.four_bank ? sdram_pkg::ROW_MIN + k
                           : sdram_pkg::ROW_MIN + int'(geom.row_extra) - 1 - k]
                    = phys_addr[hi + k];
            end
        end
        // extra column bits follow; column bit 10 rides line 11
        for (int k = 0; k < 3; k++) begin
            if (k < int'(geom.col_extra)) begin
                mapped.col[(k < 2) ? sdram_pkg::COL_MIN + k
                           : sdram_pkg::COL_TOP_LINE] =
                    phys_addr[hi + int'(geom.row_extra) + k];
            end
        end
        mapped.bank[0] = phys_addr[sdram_pkg::BA0_POS];
        if (geom.four_bank) begin
            mapped.bank[1] = phys_addr[sdram_pkg::BA1_POS];
        end
    end

endmodule : addr_map
`default_nettype wire

// File: core/sdram_ctrl.sv
// Overview of operation
// - four memory clock copies, same frequency and phase as bus clock
// - sixty-four bit bus: every burst is four beats
// - thirty-two bit bus: every burst is eight beats
// - eight chip selects, one per physical bank
// - thirteen multiplexed address lines plus two bank selects
// - address line thirteen only carries the flash address bit 23
// - read capture after latency from config register four bits 14:12
// - first write beat goes with the write command
// - byte masks per lane; array must wire each mask to its lane
// - up to four open pages tracked
// - page kept open per burst-to-precharge and page maximum counts
// - tracker of a same-bank page reused first, else a free one, else least recently used
// - chip select, bank and address reach one gigabyte
// - mapping supports x1 to x32 device widths
// - row bits 10:0 from host bits 11 to 21
// - bank select 0 from host bit 22, bank select 1 from host bit 23 with four banks only
// - column 7:0 from host 3 to 10, higher bits above banks
// - drive write enable, row strobe, column strobe, clock enable
// - eleven column bits: line 10 low, line 11 carries bit ten
// - eight byte masks, one per byte lane
`default_nettype none
module sdram_ctrl (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // configuration
    input wire logic bus_64,
    input wire sdram_pkg::geom_s geom,
    input wire logic [31:0] memory_config_four,
    input wire logic [3:0] burst_to_precharge_count,
    input wire logic [7:0] page_open_max,
    input wire logic rom_address_23,
    // host request
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [2:0] req_cs,
    input wire logic [31:0] req_addr,
    input wire logic [7:0] req_byte_en,
    output logic req_ready,
    // data path strobes and status
    output logic write_beat,
    output logic read_capture,
    output logic [sdram_pkg::NUM_PAGES-1:0] open_pages,
    // memory pins
    output logic [sdram_pkg::NUM_CLK-1:0] sdram_clk,
    output logic clock_enable,
    output logic [sdram_pkg::NUM_CS-1:0] chip_select_n,
    output logic row_strobe_n,
    output logic column_strobe_n,
    output logic write_enable_n,
    output logic [sdram_pkg::MUX_W:0] mux_address,
    output logic [sdram_pkg::BA_W-1:0] bank_select,
    output logic [sdram_pkg::MASK_W-1:0] dq_mask
);

    sdram_pkg::ctrl_s state;
    sdram_pkg::ctrl_s next_state;
    sdram_pkg::dram_addr_s req_map;
    logic hit_any, bank_any, free_any, exp_any, accept, touch;
    logic [1:0] hit_slot, bank_slot, free_slot, lru_slot, exp_slot;
    logic [1:0] victim, touch_slot;
    logic [2:0] lat_eff, lat_idx;
    logic [3:0] beats;
    logic [3:0] rank_seen;

    // ****************************************
    // address mapping
    // ****************************************
    addr_map map_u (
        .phys_addr(req_addr),
        .geom(geom),
        .mapped(req_map)
    );

    // ****************************************
    // page lookup
    // ****************************************
    // lowest slot wins every search
    always_comb begin
        hit_any = 1'b0;
        bank_any = 1'b0;
        free_any = 1'b0;
        exp_any = 1'b0;
        hit_slot = 2'h0;
        bank_slot = 2'h0;
        free_slot = 2'h0;
        lru_slot = 2'h0;
        exp_slot = 2'h0;
        rank_seen = 4'h0;
        for (int i = sdram_pkg::NUM_PAGES - 1; i >= 0; i--) begin
            rank_seen[state.pg[i].rank] = 1'b1;
            if (state.pg[i].valid && state.pg[i].cs == req_cs
                    && state.pg[i].bank == req_map.bank) begin
                if (state.pg[i].row == req_map.row) begin
                    hit_any = 1'b1;
                    hit_slot = 2'(i);
                end else begin
                    bank_any = 1'b1;
                    bank_slot = 2'(i);
                end
            end
            if (!state.pg[i].valid) begin
                free_any = 1'b1;
                free_slot = 2'(i);
            end
            if (state.pg[i].rank == 2'h3) begin
                lru_slot = 2'(i);
            end
            if (state.pg[i].valid && (state.pg[i].life == 8'h0
                    || state.pg[i].idle == 4'h0)) begin
                exp_any = 1'b1;
                exp_slot = 2'(i);
            end
        end
        victim = bank_any ? bank_slot : (free_any ? free_slot : lru_slot);
        accept = state.phase == sdram_pkg::ST_IDLE && !exp_any && req_valid;
    end

    // read latency, zero treated as one
    assign lat_eff = memory_config_four[sdram_pkg::LAT_MSB:
                                        sdram_pkg::LAT_LSB] == 3'h0 ? 3'h1
                   : memory_config_four[sdram_pkg::LAT_MSB:
                                        sdram_pkg::LAT_LSB];
    assign lat_idx = lat_eff - 3'h1;
    assign beats = bus_64 ? sdram_pkg::BEATS_64 : sdram_pkg::BEATS_32;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_state = state;
        touch = 1'b0;
        touch_slot = state.slot;
        next_state.ready = 1'b0;
        next_state.wbeat = 1'b0;
        next_state.cke = 1'b1;
        next_state.cmd = sdram_pkg::CMD_NOP;
        next_state.cs_n = '1;
        next_state.dqm = '1;
        next_state.mux = '0;
        next_state.rd_pipe = {state.rd_pipe[6:0], 1'b0};
        next_state.rcap = state.rd_pipe[lat_idx];
        // open page timers run down every clock
        for (int i = 0; i < sdram_pkg::NUM_PAGES; i++) begin
            if (state.pg[i].valid && state.pg[i].life != 8'h0) begin
                next_state.pg[i].life = state.pg[i].life - 8'h1;
            end
            if (state.pg[i].valid && state.pg[i].idle != 4'h0) begin
                next_state.pg[i].idle = state.pg[i].idle - 4'h1;
            end
        end
        unique case (state.phase)
            sdram_pkg::ST_IDLE: begin
                if (exp_any) begin
                    next_state.slot = exp_slot;
                    next_state.close_only = 1'b1;
                    next_state.phase = sdram_pkg::ST_PRE;
                end else if (req_valid) begin
                    next_state.ready = 1'b1;
                    next_state.wr = req_write;
                    next_state.cs = req_cs;
                    next_state.a = req_map;
                    next_state.be = req_byte_en;
                    next_state.close_only = 1'b0;
                    if (hit_any) begin
                        next_state.slot = hit_slot;
                        next_state.phase = sdram_pkg::ST_COL;
                    end else begin
                        next_state.slot = victim;
                        next_state.phase = state.pg[victim].valid
                            ? sdram_pkg::ST_PRE : sdram_pkg::ST_ACT;
                    end
                end
            end
            sdram_pkg::ST_PRE: begin
                // line 10 low closes only the addressed bank
                next_state.cmd = sdram_pkg::CMD_PRE;
                next_state.cs_n[state.pg[state.slot].cs] = 1'b0;
                next_state.ba = state.pg[state.slot].bank;
                next_state.pg[state.slot].valid = 1'b0;
                next_state.wait_cnt = sdram_pkg::T_RP - 3'h1;
                next_state.after = state.close_only
                    ? sdram_pkg::ST_IDLE : sdram_pkg::ST_ACT;
                next_state.phase = sdram_pkg::ST_WAIT;
            end
            sdram_pkg::ST_ACT: begin
                next_state.cmd = sdram_pkg::CMD_ACT;
                next_state.cs_n[state.cs] = 1'b0;
                next_state.ba = state.a.bank;
                next_state.mux[sdram_pkg::MUX_W-1:0] = state.a.row;
                next_state.pg[state.slot].valid = 1'b1;
                next_state.pg[state.slot].cs = state.cs;
                next_state.pg[state.slot].bank = state.a.bank;
                next_state.pg[state.slot].row = state.a.row;
                next_state.pg[state.slot].life = page_open_max;
                next_state.pg[state.slot].idle = burst_to_precharge_count;
                touch = 1'b1;
                next_state.wait_cnt = sdram_pkg::T_RCD - 3'h1;
                next_state.after = sdram_pkg::ST_COL;
                next_state.phase = sdram_pkg::ST_WAIT;
            end
            sdram_pkg::ST_COL: begin
                next_state.cmd = state.wr
                    ? sdram_pkg::CMD_WR : sdram_pkg::CMD_RD;
                next_state.cs_n[state.cs] = 1'b0;
                next_state.ba = state.a.bank;
                next_state.mux[sdram_pkg::MUX_W-1:0] = state.a.col;
                next_state.pg[state.slot].idle = burst_to_precharge_count;
                touch = 1'b1;
                next_state.beat = beats - 4'h1;
                next_state.wbeat = state.wr;
                next_state.rd_pipe[0] = !state.wr;
                next_state.phase = sdram_pkg::ST_BURST;
            end
            sdram_pkg::ST_BURST: begin
                next_state.wbeat = state.wr;
                next_state.rd_pipe[0] = !state.wr;
                next_state.beat = state.beat - 4'h1;
                if (state.beat == 4'h1) begin
                    next_state.pg[state.slot].idle = burst_to_precharge_count;
                    next_state.phase = sdram_pkg::ST_IDLE;
                end
            end
            sdram_pkg::ST_WAIT: begin
                if (state.wait_cnt == 3'h0) begin
                    next_state.phase = state.after;
                end else begin
                    next_state.wait_cnt = state.wait_cnt - 3'h1;
                end
            end
            default: begin
                next_state.phase = sdram_pkg::ST_IDLE;
            end
        endcase
        // masks: byte enables on writes, open lanes on reads, lanes 7:4 masked on a 32-bit bus
        if (state.phase == sdram_pkg::ST_COL
                || state.phase == sdram_pkg::ST_BURST) begin
            next_state.dqm = state.wr ? ~state.be : 8'h00;
            if (!bus_64) begin
                next_state.dqm[7:4] = 4'hf;
            end
        end
        // least recently used ranks: touched slot becomes newest
        if (touch) begin
            for (int i = 0; i < sdram_pkg::NUM_PAGES; i++) begin
                if (state.pg[i].rank < state.pg[touch_slot].rank) begin
                    next_state.pg[i].rank = state.pg[i].rank + 2'h1;
                end
            end
            next_state.pg[touch_slot].rank = 2'h0;
        end
        next_state.mux[sdram_pkg::ROM_LINE] = rom_address_23;
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state <= sdram_pkg::CTRL_RESET;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // clocks are the bus clock, so phase matches
    assign sdram_clk = {sdram_pkg::NUM_CLK{sys_clk}};
    assign clock_enable = state.cke;
    assign chip_select_n = state.cs_n;
    assign {row_strobe_n, column_strobe_n, write_enable_n} = state.cmd;
    assign mux_address = state.mux;
    assign bank_select = state.ba;
    assign dq_mask = state.dqm;
    assign req_ready = state.ready;
    assign write_beat = state.wbeat;
    assign read_capture = state.rcap;
    always_comb begin
        for (int i = 0; i < sdram_pkg::NUM_PAGES; i++) begin
            open_pages[i] = state.pg[i].valid;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence four_beats;
        write_beat [*4] ##1 !write_beat;
    endsequence
    sequence eight_beats;
        write_beat [*8] ##1 !write_beat;
    endsequence

    burst_four_a: assert property (
        state.cmd == sdram_pkg::CMD_WR && bus_64 |-> four_beats)
        else $error("64-bit write burst is not four beats");
    burst_eight_a: assert property (
        state.cmd == sdram_pkg::CMD_WR && !bus_64 |-> eight_beats)
        else $error("32-bit write burst is not eight beats");
    write_first_a: assert property (
        state.cmd == sdram_pkg::CMD_WR |-> write_beat && !$past(write_beat))
        else $error("first write beat not with write command");
    chip_onehot_a: assert property (
        state.cmd != sdram_pkg::CMD_NOP |-> $onehot(~chip_select_n))
        else $error("not one chip select");
    no_autopre_a: assert property (
        state.cmd == sdram_pkg::CMD_RD || state.cmd == sdram_pkg::CMD_WR
        |-> !mux_address[10])
        else $error("column phase requests autoprecharge");
    rom_line_a: assert property (
        $past(rst_n)
        |-> mux_address[sdram_pkg::ROM_LINE] == $past(rom_address_23))
        else $error("flash line wrong");
    read_lat_a: assert property (
        state.cmd == sdram_pkg::CMD_RD && lat_eff == 3'h2
        |-> ##2 read_capture)
        else $error("read latency wrong");
    hit_direct_a: assert property (
        accept && hit_any |=> state.phase == sdram_pkg::ST_COL
        ##1 state.cmd != sdram_pkg::CMD_ACT)
        else $error("hit not direct");
    miss_act_a: assert property (
        accept && !hit_any |-> ##[2:8] state.cmd == sdram_pkg::CMD_ACT)
        else $error("page miss did not activate");
    act_row_a: assert property (
        state.cmd == sdram_pkg::CMD_ACT
        |-> mux_address[sdram_pkg::MUX_W-1:0] == state.a.row)
        else $error("wrong row");
    lru_distinct_a: assert property (
        rank_seen == 4'hf)
        else $error("ranks not distinct");
    page_close_a: assert property (
        state.phase == sdram_pkg::ST_IDLE && exp_any
        |=> state.phase == sdram_pkg::ST_PRE
        ##1 state.cmd == sdram_pkg::CMD_PRE)
        else $error("expired page not precharged");

endmodule : sdram_ctrl
`default_nettype wire

// File: pkg/sdram_pkg.sv
`default_nettype none
package sdram_pkg;

    // ****************************************
    // sizes of the memory side
    // ****************************************
    localparam int NUM_CLK = 4;
    localparam int NUM_CS = 8;
    localparam int MUX_W = 13;
    localparam int BA_W = 2;
    localparam int NUM_PAGES = 4;
    localparam int MASK_W = 8;
    localparam int PA_W = 32;

    // ****************************************
    // field positions
    // ****************************************
    localparam int LAT_MSB = 14;
    localparam int LAT_LSB = 12;
    localparam int ROW_POS = 11;
    localparam int COL_POS = 3;
    localparam int BA0_POS = 22;
    localparam int BA1_POS = 23;
    localparam int HI_BASE_2B = 23;
    localparam int HI_BASE_4B = 24;
    localparam int ROW_MIN = 11;
    localparam int COL_MIN = 8;
    localparam int COL_TOP_LINE = 11;
    localparam int ROM_LINE = 13;

    // ****************************************
    // timing counts in memory clocks
    // ****************************************
    localparam logic [3:0] BEATS_64 = 4'h4;
    localparam logic [3:0] BEATS_32 = 4'h8;
    localparam logic [2:0] T_RP = 3'h2;
    localparam logic [2:0] T_RCD = 3'h2;

    // ****************************************
    // commands as {row, column, write} strobes
    // ****************************************
    localparam logic [2:0] CMD_NOP = 3'h7;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_RD = 3'h5;
    localparam logic [2:0] CMD_WR = 3'h4;
    localparam logic [2:0] CMD_PRE = 3'h2;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_PRE = 6'h02,
        ST_ACT = 6'h04,
        ST_COL = 6'h08,
        ST_BURST = 6'h10,
        ST_WAIT = 6'h20
    } phase_e;

    typedef struct packed {
        logic [1:0] row_extra;
        logic [1:0] col_extra;
        logic four_bank;
    } geom_s;

    typedef struct packed {
        logic [MUX_W-1:0] row;
        logic [MUX_W-1:0] col;
        logic [BA_W-1:0] bank;
    } dram_addr_s;

    typedef struct packed {
        logic valid;
        logic [2:0] cs;
        logic [BA_W-1:0] bank;
        logic [MUX_W-1:0] row;
        logic [7:0] life;
        logic [3:0] idle;
        logic [1:0] rank;
    } page_s;

    typedef struct packed {
        phase_e phase;
        phase_e after;
        logic close_only;
        logic [2:0] wait_cnt;
        logic [3:0] beat;
        logic wr;
        logic [2:0] cs;
        dram_addr_s a;
        logic [MASK_W-1:0] be;
        logic [1:0] slot;
        page_s [NUM_PAGES-1:0] pg;
        logic [7:0] rd_pipe;
        logic ready;
        logic wbeat;
        logic rcap;
        logic cke;
        logic [NUM_CS-1:0] cs_n;
        logic [2:0] cmd;
        logic [MUX_W:0] mux;
        logic [BA_W-1:0] ba;
        logic [MASK_W-1:0] dqm;
    } ctrl_s;

    function automatic ctrl_s reset_ctrl();
        ctrl_s c;
        c = '0;
        c.phase = ST_IDLE;
        c.after = ST_IDLE;
        c.cs_n = '1;
        c.cmd = CMD_NOP;
        c.dqm = '1;
        for (int i = 0; i < NUM_PAGES; i++) begin
            c.pg[i].rank = 2'(i);
        end
        return c;
    endfunction : reset_ctrl

    localparam ctrl_s CTRL_RESET = reset_ctrl();

endpackage : sdram_pkg
`default_nettype wire

// File: verif/sdram_device_model.sv
`default_nettype none
module sdram_device_model (
    // clock
    input wire logic sys_clk,
    // command pins
    input wire logic clock_enable,
    input wire logic [7:0] chip_select_n,
    input wire logic row_strobe_n,
    input wire logic column_strobe_n,
    input wire logic write_enable_n,
    input wire logic [1:0] bank_select,
    // illegal commands
    output int bad_cmds
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // open rows
    // ****************************************
    logic [31:0] row_open = '0;
    // tracks open rows
    always @(posedge sys_clk) begin : decode
        int slot;
        slot = 0;
        for (int i = 0; i < 8; i++) begin
            if (chip_select_n[i] === 1'b0) slot = i * 4 + int'(bank_select);
        end
        if (clock_enable === 1'b1 && chip_select_n !== 8'hff) begin
            if ($countones(~chip_select_n) != 1) bad_cmds++;
            case ({row_strobe_n, column_strobe_n, write_enable_n})
                sdram_pkg::CMD_ACT: begin
                    if (row_open[slot]) bad_cmds++;
                    row_open[slot] = 1'b1;
                end
                sdram_pkg::CMD_PRE: row_open[slot] = 1'b0;
                sdram_pkg::CMD_RD, sdram_pkg::CMD_WR: begin
                    if (!row_open[slot]) bad_cmds++;
                end
                default: ;
            endcase
        end
    end
endmodule : sdram_device_model
`default_nettype wire

// File: verif/sdram_interface_addr_mux_tb_top.sv
`default_nettype none
module sdram_interface_addr_mux_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [2:0] cmd;
        logic [7:0] cs_n;
        logic [12:0] mux, care;
        logic [1:0] ba;
        logic [7:0] dqm;
    } rec_s;
    logic sys_clk, rst_n, bus_64, rom_address_23, req_valid, req_write;
    logic req_ready, write_beat, read_capture, clock_enable, watch, rom_prev;
    logic row_strobe_n, column_strobe_n, write_enable_n;
    logic [2:0] req_cs, lat;
    logic [3:0] burst_to_precharge_count, open_pages, sdram_clk;
    logic [7:0] page_open_max, req_byte_en, chip_select_n, dq_mask;
    logic [31:0] memory_config_four, req_addr, a;
    logic [13:0] mux_address;
    logic [1:0] bank_select;
    sdram_pkg::geom_s geom;
    rec_s expq[$];
    rec_s p;
    int wbq[$], rbq[$], latq[$];
    int errors, tests_run, cyc, col_cyc, wrun, rrun, bad_cmds;

    sdram_ctrl sdram_ctrl_inst (.sys_clk(sys_clk), .rst_n(rst_n),
        .bus_64(bus_64), .geom(geom),
        .memory_config_four(memory_config_four),
        .burst_to_precharge_count(burst_to_precharge_count),
        .page_open_max(page_open_max), .rom_address_23(rom_address_23),
        .req_valid(req_valid), .req_write(req_write), .req_cs(req_cs),
        .req_addr(req_addr), .req_byte_en(req_byte_en), .req_ready(req_ready),
        .write_beat(write_beat), .read_capture(read_capture),
        .open_pages(open_pages), .sdram_clk(sdram_clk),
        .clock_enable(clock_enable), .chip_select_n(chip_select_n),
        .row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
        .write_enable_n(write_enable_n), .mux_address(mux_address),
        .bank_select(bank_select), .dq_mask(dq_mask));
    sdram_device_model sdram_device_model_inst (.sys_clk(sys_clk),
        .clock_enable(clock_enable), .chip_select_n(chip_select_n),
        .row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
        .write_enable_n(write_enable_n), .bank_select(bank_select),
        .bad_cmds(bad_cmds));

    // ****************************************
    // checking and closing
    // ****************************************
    task automatic check(input string what, input logic [31:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic close_out();
        check("device misuse", 0, bad_cmds);
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    // queues one access, then drives it
    task automatic access(input logic [31:0] ad, input logic hit);
        rec_s e;
        int k;
        @(posedge sys_clk);
        #2;
        e = '0;
        e.cs_n = ~(8'h01 << req_cs);
        e.ba = {geom.four_bank & ad[23], ad[22]};
        e.care = 13'h1fff;
        e.mux = {2'h0, ad[21:11]};
        k = geom.four_bank ? 24 : 23;
        for (int r = 0; r < geom.row_extra; r++) begin
            e.mux[geom.four_bank ? 11 + r : 12 - r] = ad[k];
            k++;
        end
        e.cmd = sdram_pkg::CMD_ACT;
        if (!hit) expq.push_back(e);
        e.mux = {5'h0, ad[10:3]};
        for (int c = 0; c < geom.col_extra; c++) begin
            e.mux[c == 2 ? 11 : 8 + c] = ad[k];
            k++;
        end
        e.cmd = req_write ? sdram_pkg::CMD_WR : sdram_pkg::CMD_RD;
        e.dqm = (req_write ? ~req_byte_en : 8'h00) | (bus_64 ? 8'h00 : 8'hf0);
        expq.push_back(e);
        if (req_write) wbq.push_back(bus_64 ? 4 : 8);
        else rbq.push_back(bus_64 ? 4 : 8);
        if (!req_write) latq.push_back(int'(lat));
        req_addr = ad;
        req_valid = 1'b1;
        for (k = 0; k < 100 && req_ready !== 1'b1; k++) @(posedge sys_clk);
        #2 req_valid = 1'b0;
        if (k == 100) check("ready wait", 1, 0);
        if (k == 100) close_out();
    endtask : access

    // waits for pages to close
    task automatic quiesce();
        repeat (40) @(posedge sys_clk);
        #2;
        check("open pages", 4'h0, open_pages);
        check("queued commands", 0, expq.size());
    endtask : quiesce

    // compares pins as they appear
    always @(posedge sys_clk) begin : watcher
        logic [2:0] c;
        rec_s e;
        cyc++;
        c = {row_strobe_n, column_strobe_n, write_enable_n};
        if (watch && c !== sdram_pkg::CMD_NOP && (c !== sdram_pkg::CMD_PRE
                || (expq.size() > 0 && expq[0].cmd == sdram_pkg::CMD_PRE))) begin
            e = expq.size() > 0 ? expq.pop_front() : '0;
            check("command", e.cmd, c);
            check("chip select", e.cs_n, chip_select_n);
            check("bank", e.ba, bank_select);
            check("address", e.mux & e.care, mux_address[12:0] & e.care);
            if (c[2:1] === 2'b10) col_cyc = cyc;
            if (c[2:1] === 2'b10) check("byte mask", e.dqm, dq_mask);
            if (c === sdram_pkg::CMD_WR) check("first beat", 1, write_beat);
        end
        if (watch) check("flash line", rom_prev, mux_address[13]);
        rom_prev = rom_address_23;
        if (write_beat === 1'b1) wrun++;
        else if (wrun > 0) check("write beats", wbq.pop_front(), wrun);
        if (write_beat !== 1'b1) wrun = 0;
        if (read_capture === 1'b1 && rrun == 0)
            check("read latency", latq.pop_front(), cyc - col_cyc);
        if (read_capture === 1'b1) rrun++;
        else if (rrun > 0) check("read beats", rbq.pop_front(), rrun);
        if (read_capture !== 1'b1) rrun = 0;
    end

    // clock and random flash bit
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) rom_address_23 <= #2 1'($urandom);

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        void'($urandom(39));
        {rst_n, req_valid, req_write, watch, rom_address_23, rom_prev} = '0;
        {bus_64, geom, memory_config_four, req_cs, req_addr, a} = '0;
        {burst_to_precharge_count, page_open_max, req_byte_en} = 20'hfffff;
        {errors, tests_run, cyc, col_cyc, wrun, rrun, lat} = '0;
        repeat (4) @(posedge sys_clk);
        #2;
        check("clock enable", 1'b0, clock_enable);
        check("selects idle", 8'hff, chip_select_n);
        check("masks idle", 8'hff, dq_mask);
        check("clock copies", 4'hf, sdram_clk);
        rst_n = 1'b1;
        @(posedge sys_clk);
        #2;
        check("clock enable", 1'b1, clock_enable);
        watch = 1'b1;
        $display("test reset done");
        for (int i = 0; i < 12; i++) begin
            quiesce();
            bus_64 = 1'($urandom);
            geom.four_bank = 1'($urandom);
            geom.row_extra = geom.four_bank ? 2'($urandom % 3)
                : 2'(($urandom % 2) * 2);
            geom.col_extra = (geom.four_bank && geom.row_extra == 0) ? 2'h0
                : 2'($urandom % (geom.four_bank ? 4 : 3));
            lat = 3'(1 + $urandom % 3);
            memory_config_four = $urandom;
            memory_config_four[14:12] = lat;
            {req_write, req_cs, req_byte_en} = 12'($urandom);
            a = $urandom;
            access(a, 1'b0);
            req_write = ~req_write;
            access({a[31:11], 11'($urandom)}, 1'b1);
        end
        $display("test mapping done");
        quiesce();
        req_write = 1'b1;
        access(a, 1'b0);
        p = '0;
        p.cmd = sdram_pkg::CMD_PRE;
        p.cs_n = ~(8'h01 << req_cs);
        p.ba = {geom.four_bank & a[23], a[22]};
        p.care = 13'h0400;
        expq.push_back(p);
        access(a ^ 32'h0000_0800, 1'b0);
        quiesce();
        $display("test page miss done");
        close_out();
    end
endmodule : sdram_interface_addr_mux_tb_top
`default_nettype wire
